// >>> hw/adcf_top.v
// output word formatting and serial/parallel mode configuration port
// Functional notes
// [RULE_01] randomizer xors every data bit above the lsb with the lsb
// [RULE_02] randomizer leaves lsb, overflow flag and output clock untouched
// [RULE_03] receiver un-randomizes by xoring upper bits with received lsb
// [RULE_04] alternate polarity inverts odd data bits only
// [RULE_05] randomizer and alternate polarity combine freely; receiver reinverts odd bits
// [RULE_06] test patterns: all ones, all zeros, or alternating ones/zeros
// [RULE_07] checkerboard alternates two complementary alternating-bit words
// [RULE_08] test pattern overrides twos complement, randomizer and polarity
// [RULE_09] output disable tristates data, overflow flag and output clock
// [RULE_10] host waits 100 sample clocks after nap before trusting data
// [RULE_11] only channel 2 nap or both nap; never channel 1 alone
// [RULE_12] interface select pin high means parallel, low means serial
// [RULE_13] parallel mode: chip select pin sets duty cycle stabilizer
// [RULE_14] parallel mode: serial clock pin selects cmos or lvds 3.5ma
// [RULE_15] parallel mode: two data pins encode power state
// [RULE_16] frame is chip select low; sdi sampled on first 16 edges
// [RULE_17] serial clock rising edges beyond sixteenth are ignored
// [RULE_18] word order: read/write flag, seven address bits, eight data bits
// [RULE_19] write flag low stores data byte at address
// [RULE_20] read shifts register out on sdo, no update, sdi ignored
// [RULE_21] host's first serial command is a software reset write
// [RULE_22] software reset clears all mode control bits
// [RULE_23] reset trigger bit returns to zero after the write
// [RULE_24] written configuration applies to samples after the frame ends
`timescale 1ns/100ps
`default_nettype none
`include "adcf_defines.vh"

module adcf_top (
    // clock and reset
    input  wire        clock,
    input  wire        nrst,
    // sample path
    input  wire        sample_valid,
    input  wire [11:0] ch1_data,
    input  wire        ch1_overflow,
    input  wire [11:0] ch2_data,
    input  wire        ch2_overflow,
    input  wire        enc_clock_level,
    // formatted outputs, enables low while driven
    output reg  [11:0] ch1_out_reg,
    output reg         ch1_overflow_flag_reg,
    output reg  [11:0] ch2_out_reg,
    output reg         ch2_overflow_flag_reg,
    output reg         output_data_clock_reg,
    output wire        out_oe_n,
    // configuration pins
    input  wire        interface_select_pin,
    input  wire        cs_n_pin,
    input  wire        sck_pin,
    input  wire        sdi_pin,
    input  wire        sdo_in,
    output wire        sdo_out,
    output wire        sdo_oe_n,
    // decoded configuration
    output wire        dcs_enable,
    output wire [1:0]  output_mode,
    output wire [2:0]  lvds_current,
    output wire        lvds_term_en,
    output wire        ch1_nap,
    output wire        ch2_nap,
    output wire        sleep,
    output wire [7:0]  clock_timing
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [1:0] sel_sync_reg, cs_sync_reg, sck_sync_reg, sdi_sync_reg, sdo_sync_reg;
reg [1:0] enc_sync_reg;
reg       sck_prev_reg, enc_prev_reg;

always @(posedge clock) begin
    if (!nrst) begin
        sel_sync_reg <= 2'h0;
        cs_sync_reg  <= 2'h3;
        sck_sync_reg <= 2'h0;
        sdi_sync_reg <= 2'h0;
        sdo_sync_reg <= 2'h0;
        enc_sync_reg <= 2'h0;
        sck_prev_reg <= 1'b0;
        enc_prev_reg <= 1'b0;
    end else begin
        sel_sync_reg <= {sel_sync_reg[0], interface_select_pin};
        cs_sync_reg  <= {cs_sync_reg[0], cs_n_pin};
        sck_sync_reg <= {sck_sync_reg[0], sck_pin};
        sdi_sync_reg <= {sdi_sync_reg[0], sdi_pin};
        sdo_sync_reg <= {sdo_sync_reg[0], sdo_in};
        enc_sync_reg <= {enc_sync_reg[0], enc_clock_level};
        sck_prev_reg <= sck_sync_reg[1];
        enc_prev_reg <= enc_sync_reg[1];
    end
end

wire parallel_mode = sel_sync_reg[1]; // [RULE_12]
wire cs_n   = cs_sync_reg[1];
wire sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
wire sck_fall = ~sck_sync_reg[1] & sck_prev_reg;
wire enc_rise = enc_sync_reg[1] & ~enc_prev_reg;

////////////////////////////////////////////////////////////////////////////////
// serial port
reg [`ADCF_CNT_W-1:0] bit_cnt_reg;
reg [15:0]            shift_reg;
reg [7:0]             rd_shift_reg;
reg                   sdo_drive_low_reg;
reg                   frame_reg;
reg                   read_reg;
reg [7:0]  power_reg, timing_reg, outmode_reg, format_reg;
reg [7:0]  reset_reg;

function [7:0] reg_read;
    input [6:0] addr;
    begin
        case (addr)
            `ADCF_ADDR_RESET:   reg_read = reset_reg;
            `ADCF_ADDR_POWER:   reg_read = power_reg;
            `ADCF_ADDR_TIMING:  reg_read = timing_reg;
            `ADCF_ADDR_OUTMODE: reg_read = outmode_reg;
            `ADCF_ADDR_FORMAT:  reg_read = format_reg;
            default:            reg_read = `ADCF_REG_ZERO;
        endcase
    end
endfunction

wire serial_active = ~parallel_mode & ~cs_n;
wire take_bit = serial_active & sck_rise & (bit_cnt_reg < `ADCF_FRAME_BITS); // [RULE_16] [RULE_17]
wire [15:0] shift_next = {shift_reg[14:0], sdi_sync_reg[1]};
// frame end commits the write, so formatting sees it only afterwards
wire frame_end = frame_reg & (cs_n | parallel_mode); // [RULE_24]
wire do_write = frame_end & (bit_cnt_reg == `ADCF_FRAME_BITS) & ~shift_reg[15]; // [RULE_19]
wire [6:0] wr_addr = shift_reg[14:8]; // [RULE_18]
wire [7:0] wr_data = shift_reg[7:0];
wire soft_reset = do_write & (wr_addr == `ADCF_ADDR_RESET) & wr_data[`ADCF_RESET_BIT];

always @(posedge clock) begin
    if (!nrst) begin
        bit_cnt_reg       <= {`ADCF_CNT_W{1'b0}};
        shift_reg         <= 16'h0000;
        rd_shift_reg      <= `ADCF_REG_ZERO;
        sdo_drive_low_reg <= 1'b0;
        frame_reg         <= 1'b0;
        read_reg          <= 1'b0;
    end else begin
        frame_reg <= serial_active;
        if (!serial_active) begin
            bit_cnt_reg       <= {`ADCF_CNT_W{1'b0}};
            sdo_drive_low_reg <= 1'b0;
            read_reg          <= 1'b0;
        end else if (take_bit) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            shift_reg   <= shift_next;
            // address complete after eighth bit: latch read data
            if (bit_cnt_reg == 5'h07) begin
                read_reg     <= shift_next[7]; // [RULE_20]
                rd_shift_reg <= reg_read(shift_next[6:0]);
            end
        end else if (sck_fall && read_reg && bit_cnt_reg >= 5'h08) begin
            // drive data bit after falling edge, msb first
            sdo_drive_low_reg <= ~rd_shift_reg[7]; // [RULE_20]
            rd_shift_reg      <= {rd_shift_reg[6:0], 1'b0};
        end
    end
end

// open drain: only ever pulls low
assign sdo_out  = 1'b0;
assign sdo_oe_n = ~sdo_drive_low_reg;

////////////////////////////////////////////////////////////////////////////////
// mode control registers
always @(posedge clock) begin
    if (!nrst || soft_reset) begin
        power_reg   <= `ADCF_REG_ZERO; // [RULE_22]
        timing_reg  <= `ADCF_REG_ZERO;
        outmode_reg <= `ADCF_REG_ZERO;
        format_reg  <= `ADCF_REG_ZERO;
        reset_reg   <= `ADCF_REG_ZERO; // [RULE_23]
    end else if (do_write) begin
        case (wr_addr)
            `ADCF_ADDR_POWER:   power_reg   <= wr_data; // [RULE_19]
            `ADCF_ADDR_TIMING:  timing_reg  <= wr_data;
            `ADCF_ADDR_OUTMODE: outmode_reg <= wr_data;
            `ADCF_ADDR_FORMAT:  format_reg  <= wr_data;
            default:            reset_reg   <= `ADCF_REG_ZERO;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// effective configuration
wire [1:0] par_power = {sdi_sync_reg[1], sdo_sync_reg[1]}; // [RULE_15]
wire [1:0] power_code = parallel_mode ? par_power : power_reg[1:0];

assign sleep   = (power_code == `ADCF_PWR_SLEEP);
// no code naps channel 1 alone
assign ch2_nap = (power_code == `ADCF_PWR_NAP2) | (power_code == `ADCF_PWR_NAPALL); // [RULE_11]
assign ch1_nap = (power_code == `ADCF_PWR_NAPALL); // [RULE_11]

assign dcs_enable   = parallel_mode ? cs_n : timing_reg[0]; // [RULE_13]
assign output_mode  = parallel_mode ? (sck_sync_reg[1] ? `ADCF_MODE_LVDS : `ADCF_MODE_CMOS)
                                    : outmode_reg[`ADCF_OUT_MODE_HI:`ADCF_OUT_MODE_LO]; // [RULE_14]
assign lvds_current = parallel_mode ? `ADCF_LVDS_3P5MA : outmode_reg[6:4];
assign lvds_term_en = parallel_mode ? 1'b0 : outmode_reg[3]; // [RULE_14]
assign clock_timing = parallel_mode ? `ADCF_REG_ZERO : timing_reg;

wire [7:0] fmt     = parallel_mode ? `ADCF_REG_ZERO : format_reg;
wire       out_dis = ~parallel_mode & outmode_reg[`ADCF_OUT_DIS];
assign out_oe_n = out_dis; // [RULE_09]

////////////////////////////////////////////////////////////////////////////////
// output formatting
reg phase_reg;

function [12:0] fmt_word;
    input [11:0] d;
    input        ovf;
    input [7:0]  f;
    input        ph;
    reg   [11:0] w;
    reg   [12:0] tp;
    begin
        w  = d;
        tp = 13'h0000;
        if (f[`ADCF_FMT_TWOS])
            w[`ADCF_MSB] = ~w[`ADCF_MSB];
        if (f[`ADCF_FMT_RAND])
            w = w ^ {{11{w[0]}}, 1'b0}; // [RULE_01] [RULE_02]
        if (f[`ADCF_FMT_ABP])
            w = w ^ `ADCF_ODD_MASK; // [RULE_04] [RULE_05]
        case (f[`ADCF_FMT_TP_HI:`ADCF_FMT_TP_LO])
            `ADCF_TP_ONES:  tp = 13'h1FFF; // [RULE_06]
            `ADCF_TP_ZEROS: tp = 13'h0000;
            `ADCF_TP_ALT:   tp = ph ? 13'h0000 : 13'h1FFF;
            `ADCF_TP_CHECK: tp = ph ? ~`ADCF_CHECK_A : `ADCF_CHECK_A; // [RULE_07]
            default:        tp = 13'h0000;
        endcase
        if (f[`ADCF_FMT_TP_EN])
            fmt_word = tp; // [RULE_08]
        else
            fmt_word = {ovf, w};
    end
endfunction

wire [12:0] ch1_word = fmt_word(ch1_data, ch1_overflow, fmt, phase_reg);
wire [12:0] ch2_word = fmt_word(ch2_data, ch2_overflow, fmt, phase_reg);

always @(posedge clock) begin
    if (!nrst) begin
        phase_reg             <= 1'b0;
        ch1_out_reg           <= 12'h000;
        ch1_overflow_flag_reg <= 1'b0;
        ch2_out_reg           <= 12'h000;
        ch2_overflow_flag_reg <= 1'b0;
        output_data_clock_reg <= 1'b0;
    end else begin
        // clock passes through unaffected by formatting
        output_data_clock_reg <= enc_sync_reg[1]; // [RULE_02]
        if (sample_valid) begin
            phase_reg             <= ~phase_reg;
            ch1_out_reg           <= ch1_word[11:0];
            ch1_overflow_flag_reg <= ch1_word[12];
            ch2_out_reg           <= ch2_word[11:0];
            ch2_overflow_flag_reg <= ch2_word[12];
        end
    end
end

// enc_rise kept for alignment of host capture; unused internally
wire unused_ok = enc_rise;

endmodule
`default_nettype wire

// >>> include/adcf_defines.vh
// constants for the output format and configuration port block
`ifndef ADCF_DEFINES_VH
`define ADCF_DEFINES_VH
`define ADCF_FRAME_BITS   5'h10
`define ADCF_CNT_W        5
`define ADCF_ADDR_RESET   7'h00
`define ADCF_ADDR_POWER   7'h01
`define ADCF_ADDR_TIMING  7'h02
`define ADCF_ADDR_OUTMODE 7'h03
`define ADCF_ADDR_FORMAT  7'h04
`define ADCF_RESET_BIT    7
`define ADCF_REG_ZERO     8'h00
// format register fields
`define ADCF_FMT_TWOS     0
`define ADCF_FMT_RAND     1
`define ADCF_FMT_ABP      2
`define ADCF_FMT_TP_EN    3
`define ADCF_FMT_TP_LO    4
`define ADCF_FMT_TP_HI    5
// output mode register fields
`define ADCF_OUT_DIS      0
`define ADCF_OUT_MODE_LO  1
`define ADCF_OUT_MODE_HI  2
// test pattern codes
`define ADCF_TP_ONES      2'h0
`define ADCF_TP_ZEROS     2'h1
`define ADCF_TP_ALT       2'h2
`define ADCF_TP_CHECK     2'h3
`define ADCF_CHECK_A      13'h1555
`define ADCF_ODD_MASK     12'hAAA
`define ADCF_MSB          11
// power codes
`define ADCF_PWR_NORMAL   2'h0
`define ADCF_PWR_NAP2     2'h1
`define ADCF_PWR_NAPALL   2'h2
`define ADCF_PWR_SLEEP    2'h3
// output modes
`define ADCF_MODE_CMOS    2'h0
`define ADCF_MODE_LVDS    2'h2
`define ADCF_LVDS_3P5MA   3'h4
`endif

// >>> verification/adcf_host.sv
// host model: serial frames and parallel strap levels
`timescale 1ns/100ps
`default_nettype none
module adcf_host (
    // system clock and returned sdo line
    input  wire logic clock,
    input  wire logic sdo_line,
    // configuration pins
    output var logic  cs_n,
    output var logic  sck,
    output var logic  sdi
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // sck half period is four clocks; n above 16 sends extra edges
    task automatic frame(input logic [15:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clock) cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi <= w[15 - (i % 16)];
            repeat (4) @(posedge clock);
            if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line};
            sck <= 1'b1;
            repeat (4) @(posedge clock);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clock);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (6) @(posedge clock);
    endtask
    task automatic pins(input logic [2:0] v);
        @(posedge clock) {cs_n, sck, sdi} <= v;
    endtask
endmodule
`default_nettype wire

// >>> verification/adcf_top_asserts.sv
// pin-level assertions for the format and configuration port
`timescale 1ns/100ps
`default_nettype none
module adcf_chk (
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // samples and outputs
    input wire logic        sample_valid,
    input wire logic [11:0] ch1_data,
    input wire logic        ch1_overflow,
    input wire logic        enc_clock_level,
    input wire logic [11:0] ch1_out_reg,
    input wire logic        ch1_overflow_flag_reg,
    input wire logic        output_data_clock_reg,
    input wire logic        out_oe_n,
    // pins and decoded modes
    input wire logic        interface_select_pin,
    input wire logic        cs_n_pin,
    input wire logic        sck_pin,
    input wire logic        sdi_pin,
    input wire logic        sdo_in,
    input wire logic        dcs_enable,
    input wire logic [1:0]  output_mode,
    input wire logic [2:0]  lvds_current,
    input wire logic        lvds_term_en,
    input wire logic        ch1_nap,
    input wire logic        ch2_nap,
    input wire logic        sleep
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // pins need two synchroniser stages, so wait four steady edges
    sequence par_held;
        (interface_select_pin && $stable({cs_n_pin, sck_pin, sdi_pin, sdo_in}))[*4];
    endsequence
    sequence par_sample;
        interface_select_pin[*4] ##0 sample_valid;
    endsequence
    a_par_dcs: assert property (par_held |-> dcs_enable == cs_n_pin)
        else $error("duty stabilizer differs from pin");
    a_par_mode: assert property (par_held |-> output_mode == {sck_pin, 1'b0} && !lvds_term_en)
        else $error("output mode differs from pin");
    a_par_cur: assert property (par_held ##0 sck_pin |-> lvds_current == 3'h4)
        else $error("lvds current not default");
    a_par_sleep: assert property (par_held |-> sleep == (sdi_pin && sdo_in))
        else $error("sleep differs from pins");
    a_par_nap: assert property (par_held ##0 !(sdi_pin && sdo_in) |-> ch1_nap == sdi_pin && ch2_nap == (sdi_pin || sdo_in))
        else $error("nap differs from pins");
    a_nap_order: assert property (ch1_nap |-> ch2_nap)
        else $error("channel 1 naps alone");
    a_par_pass: assert property (par_sample |=> ch1_out_reg == $past(ch1_data) && ch1_overflow_flag_reg == $past(ch1_overflow) && !out_oe_n)
        else $error("parallel sample not passed through");
    a_clk_delay: assert property ($past(nrst, 3) |-> output_data_clock_reg == $past(enc_clock_level, 3))
        else $error("output clock not a delayed encode clock");
endmodule
`default_nettype wire

// >>> verification/adcf_top_tb.sv
// self-checking bench for the format and configuration port
`timescale 1ns/100ps
`default_nettype none
module adcf_top_tb;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        sample_valid = 1'b0;
    logic [11:0] ch1_data = 12'h000;
    logic        ch1_ovf = 1'b0;
    logic        enc = 1'b0;
    logic        par = 1'b1;
    logic        sdo_drv = 1'b0;
    logic [11:0] ch1_out;
    logic [11:0] ch2_out;
    logic        ch1_of;
    logic        ch2_of;
    logic        oclk;
    logic        out_oe_n;
    logic        sdo_out;
    logic        sdo_oe_n;
    logic        dcs;
    logic        term;
    logic        nap1;
    logic        nap2;
    logic        slp;
    logic [1:0]  omode;
    logic [2:0]  cur;
    logic [7:0]  rd;
    logic [12:0] g1;
    logic [12:0] g2;
    logic [12:0] e;
    logic [12:0] a;
    logic [11:0] u;
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;
    wire         cs_n;
    wire         sck;
    wire         sdi;
    // open drain with pull-up
    wire         sdo_line = sdo_oe_n ? 1'b1 : sdo_out;
    wire         sdo_pin = par ? sdo_drv : sdo_line;
    always #25 clock = ~clock;
    adcf_host u_host (.clock(clock), .sdo_line(sdo_line), .cs_n(cs_n), .sck(sck), .sdi(sdi));
    adcf_top u_dut (.clock(clock), .nrst(nrst), .sample_valid(sample_valid),
        .ch1_data(ch1_data), .ch1_overflow(ch1_ovf), .ch2_data(~ch1_data),
        .ch2_overflow(ch1_ovf), .enc_clock_level(enc), .ch1_out_reg(ch1_out),
        .ch1_overflow_flag_reg(ch1_of), .ch2_out_reg(ch2_out),
        .ch2_overflow_flag_reg(ch2_of), .output_data_clock_reg(oclk),
        .out_oe_n(out_oe_n), .interface_select_pin(par), .cs_n_pin(cs_n),
        .sck_pin(sck), .sdi_pin(sdi), .sdo_in(sdo_pin), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .dcs_enable(dcs), .output_mode(omode),
        .lvds_current(cur), .lvds_term_en(term), .ch1_nap(nap1), .ch2_nap(nap2),
        .sleep(slp), .clock_timing());
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
        checks++;
        if (g !== ex) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, g);
        end
    endtask
    // one sample pair; ch2 carries the complement of ch1 data with the same overflow bit
    task automatic samp(input logic [12:0] w);
        @(posedge clock) {ch1_ovf, ch1_data} <= w;
        sample_valid <= 1'b1;
        enc <= ~enc;
        @(posedge clock) sample_valid <= 1'b0;
        @(negedge clock) g1 = {ch1_of, ch1_out};
        g2 = {ch2_of, ch2_out};
    endtask
    function automatic logic [12:0] fmt(input logic [12:0] w, input logic [7:0] f);
        logic [11:0] d;
        d = w[11:0] ^ (f[0] ? 12'h800 : 12'h000);
        if (f[1]) d = d ^ {{11{d[0]}}, 1'b0};
        if (f[2]) d = d ^ 12'hAAA;
        return {w[12], d};
    endfunction
    task automatic wr(input logic [6:0] ad, input logic [7:0] v);
        u_host.frame({1'b0, ad, v}, 16, rd);
    endtask
    // data byte of ones must be ignored on a read
    task automatic rdr(input logic [6:0] ad);
        u_host.frame({1'b1, ad, 8'hFF}, 16, rd);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_par;
        for (int c = 0; c < 8; c++) begin
            u_host.pins({c[2], c[0], c[1]});
            sdo_drv <= c[0];
            repeat (5) @(posedge clock);
            chk("dcs", c[2], dcs);
            chk("mode", {c[0], 1'b0}, omode);
            chk("cur", 3'h4, cur);
            chk("term", 1'b0, term);
            chk("sleep", c[1] & c[0], slp);
            if (!(c[1] & c[0])) chk("nap", {c[1], c[1] | c[0]}, {nap1, nap2});
            samp({c[0], 12'hA53});
            chk("pass", {c[0], 12'hA53}, g1);
            chk("pass2", {c[0], 12'h5AC}, g2);
        end
    endtask
    task automatic t_reset;
        @(posedge clock) par <= 1'b0;
        u_host.pins(3'b100);
        repeat (4) @(posedge clock);
        wr(7'h00, 8'h80);
        wr(7'h04, 8'h07);
        wr(7'h01, 8'h02);
        wr(7'h00, 8'h80);
        rdr(7'h00);
        chk("rst reg", 16'h0, rd);
        rdr(7'h04);
        chk("fmt clr", 16'h0, rd);
        chk("nap clr", 16'h0, {nap1, nap2});
    endtask
    task automatic t_fmt;
        for (int f = 0; f < 8; f++) begin
            wr(7'h04, f[7:0]);
            rdr(7'h04);
            chk("fmt rd", f[7:0], rd);
            samp(13'h1E35);
            chk("fmt1", fmt(13'h1E35, f[7:0]), g1);
            chk("fmt2", fmt(13'h11CA, f[7:0]), g2);
            u = g1[11:0];
            if (f[2]) u ^= 12'hAAA;
            if (f[1]) u ^= {{11{u[0]}}, 1'b0};
            chk("unrand", 12'hE35 ^ (f[0] ? 12'h800 : 12'h000), u);
        end
    endtask
    task automatic t_edges;
        u_host.frame({1'b0, 7'h04, 8'h02}, 17, rd);
        u_host.frame({1'b0, 7'h04, 8'h04}, 8, rd);
        rdr(7'h04);
        chk("extra", 16'h02, rd);
        samp(13'h0E35);
        chk("rand", fmt(13'h0E35, 8'h02), g1);
    endtask
    // pattern phase is free, so pairs are judged in either order
    task automatic t_tp;
        for (int c = 0; c < 4; c++) begin
            wr(7'h04, {2'b00, c[1:0], 4'hF});
            samp(13'h0E35);
            e = g1;
            samp(13'h0E35);
            a = c[1] ? (c[0] ? 13'h1555 : 13'h1FFF) : (c[0] ? 13'h0000 : 13'h1FFF);
            if (c[1]) chk("tp alt", 1, (e === a && g1 === ~a) || (e === ~a && g1 === a));
            else chk("tp", {3'b000, a}, {3'b000, g1});
            chk("tp fmt", c[1] ? 13'h1FFF : 13'h0000, e ^ g1);
        end
    endtask
    task automatic t_dis;
        wr(7'h03, 8'h01);
        chk("off", 1, out_oe_n);
        wr(7'h01, 8'h01);
        chk("nap2", 2'b01, {nap1, nap2});
        wr(7'h01, 8'h02);
        chk("napall", 2'b11, {nap1, nap2});
        wr(7'h03, 8'h00);
        chk("on", 0, out_oe_n);
        // wake from nap, then wait the recovery time before trusting data
        wr(7'h04, 8'h00);
        wr(7'h01, 8'h00);
        repeat (100) @(posedge clock);
        samp(13'h0E35);
        chk("wake", 13'h0E35, g1);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_par();
        t_reset();
        t_fmt();
        t_edges();
        t_tp();
        t_dis();
        end_sim();
    end
endmodule
bind adcf_top adcf_chk u_chk (.clock(clock), .nrst(nrst), .sample_valid(sample_valid),
    .ch1_data(ch1_data), .ch1_overflow(ch1_overflow), .enc_clock_level(enc_clock_level),
    .ch1_out_reg(ch1_out_reg), .ch1_overflow_flag_reg(ch1_overflow_flag_reg),
    .output_data_clock_reg(output_data_clock_reg), .out_oe_n(out_oe_n),
    .interface_select_pin(interface_select_pin), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .sdi_pin(sdi_pin), .sdo_in(sdo_in), .dcs_enable(dcs_enable), .output_mode(output_mode),
    .lvds_current(lvds_current), .lvds_term_en(lvds_term_en), .ch1_nap(ch1_nap),
    .ch2_nap(ch2_nap), .sleep(sleep));
`default_nettype wire
